//--- include/ssw_defs.svh
// timing, register map and reset constants of the supply supervisor
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

`define SSW_CLK_PERIOD_NS 50
`define SSW_MS_NS         1000000

// watchdog and reset periods in ms on the internal time base
`define SSW_WD_FAST_MS    13'h064
`define SSW_WD_SLOW_MS    13'h640
`define SSW_RST_MS        13'h0c8

// same periods in cycles of the external oscillator
`define SSW_EXT_WD_CLK    13'h400
`define SSW_EXT_FIRST_CLK 13'h1000
`define SSW_EXT_RST_CLK   13'h800

`define SSW_KICK_MIN_NS   100
`define SSW_KICK_MIN_CYC  \
  ((`SSW_KICK_MIN_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
`define SSW_CE_HOLD_NS    16000
`define SSW_CE_HOLD_CYC   (`SSW_CE_HOLD_NS / `SSW_CLK_PERIOD_NS)

`define SSW_OFF_CTRL      4'h0
`define SSW_OFF_STATUS    4'h4
`define SSW_CTRL_WD_EN    0
`define SSW_CTRL_RST      1'h1
`define SSW_RESP_OKAY     2'h0
`define SSW_RESP_SLVERR   2'h2

`endif

//--- include/ssw_pkg.sv
// types shared by the supply supervisor files
`default_nettype none
package ssw_pkg;

  typedef enum logic [1:0] {
    RS_HOLD  = 2'b00,
    RS_PULSE = 2'b01,
    RS_RUN   = 2'b10
  } ssw_rs_type;

  typedef enum logic [1:0] {
    PER_WD    = 2'b00,
    PER_FIRST = 2'b01,
    PER_RST   = 2'b10
  } ssw_per_type;

endpackage : ssw_pkg
`default_nettype wire

//--- rtl/ssw_sync.sv
// two-stage level synchroniser, one chain per bit
`default_nettype none
module ssw_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        meta_q[i] <= 1'b0;
        q_o[i]    <= 1'b0;
      end else begin
        meta_q[i] <= d_i[i];
        q_o[i]    <= meta_q[i];
      end
    end
  end

endmodule : ssw_sync
`default_nettype wire

//--- rtl/ssw_supervisor.sv
// supply supervisor: reset sequencing, watchdog, flags, chip-select gate
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
`include "ssw_defs.svh"
module ssw_supervisor #(
  parameter int unsigned MS_CYCLES = `SSW_MS_NS / `SSW_CLK_PERIOD_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        supply_ok_i,
  input  wire logic        below_batt_i,
  input  wire logic        pf_above_i,
  input  wire logic        wd_kick_hi_i,
  input  wire logic        wd_kick_lo_i,
  input  wire logic        osc_source_sel_i,
  input  wire logic        osc_ext_in_i,
  input  wire logic        mem_sel_in_n_i,
  output logic             rst_n_o,
  output logic             rst_o,
  output logic             supply_low_n_o,
  output logic             on_battery_o,
  output logic             wd_fault_n_o,
  output logic             pf_flag_n_o,
  output logic             mem_sel_out_n_o,
  output logic             wd_bias_en_o,
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  function automatic logic [12:0] period_limit(
    input logic                 ext,
    input logic                 osc_hi,
    input ssw_pkg::ssw_per_type kind
  );
    logic [12:0] v;
    v = 13'h0000;
    unique case (kind)
      ssw_pkg::PER_WD: begin
        if (ext) v = `SSW_EXT_WD_CLK;
        else     v = osc_hi ? `SSW_WD_SLOW_MS : `SSW_WD_FAST_MS;
      end
      ssw_pkg::PER_FIRST: begin
        v = ext ? `SSW_EXT_FIRST_CLK : `SSW_WD_SLOW_MS;
      end
      ssw_pkg::PER_RST: begin
        v = ext ? `SSW_EXT_RST_CLK : `SSW_RST_MS;
      end
    endcase
    return v;
  endfunction : period_limit

  function automatic logic reg_hit(input logic [3:0] addr);
    return ({addr[3:2], 2'b00} == `SSW_OFF_CTRL) ||
           ({addr[3:2], 2'b00} == `SSW_OFF_STATUS);
  endfunction : reg_hit

  // synchronised comparator and pin levels
  logic [5:0]  raw_w;
  logic [5:0]  sync_w;
  logic        sup_ok_s;
  logic        below_batt_s;
  logic        pf_s;
  logic        kick_hi_s;
  logic        kick_lo_s;
  logic        osc_s;

  assign raw_w = {osc_ext_in_i, wd_kick_lo_i, wd_kick_hi_i,
                  pf_above_i, below_batt_i, supply_ok_i};

  ssw_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (raw_w),
    .q_o     (sync_w)
  );

  assign {osc_s, kick_lo_s, kick_hi_s, pf_s, below_batt_s, sup_ok_s} =
    sync_w;

  // time base
  logic        ext_mode;
  logic        osc_prev_q;
  logic        ext_tick;
  logic        ms_tick;
  logic        tick;
  logic [14:0] pre_q;
  logic [14:0] pre_d;
  logic        st_change;

  assign ext_mode = !osc_source_sel_i;
  assign ext_tick = osc_s && !osc_prev_q;
  assign ms_tick  = (pre_q == 15'(MS_CYCLES - 1));
  assign tick     = ext_mode ? ext_tick : ms_tick;
  // restarting the prescaler on each state change keeps periods whole
  assign pre_d    = (ms_tick || st_change) ? 15'h0000 : pre_q + 15'h0001;

  // kick input: three levels, change accepted after a stable minimum
  logic        kick_mid;
  logic        kick_lvl_q;
  logic        kick_diff;
  logic        kick_edge;
  logic [1:0]  stab_q;
  logic [1:0]  stab_d;

  assign kick_mid  = !kick_hi_s && !kick_lo_s;
  assign kick_diff = !kick_mid && (kick_hi_s != kick_lvl_q);
  assign kick_edge = kick_diff &&
                     (stab_q == 2'(`SSW_KICK_MIN_CYC - 1));
  assign stab_d    = (kick_diff && !kick_edge) ? stab_q + 2'h1 : 2'h0;

  // reset sequencer and watchdog timer
  ssw_pkg::ssw_rs_type st_q;
  ssw_pkg::ssw_rs_type st_d;
  logic [12:0] tm_q;
  logic [12:0] tm_d;
  logic [12:0] wd_lim;
  logic [12:0] rs_lim;
  logic        first_q;
  logic        first_d;
  logic        fault_q;
  logic        fault_d;
  logic        wd_act;
  logic        ctrl_wd_en_q;

  assign wd_lim = period_limit(ext_mode, osc_s,
                    first_q ? ssw_pkg::PER_FIRST
                            : ssw_pkg::PER_WD);
  assign rs_lim = period_limit(ext_mode, osc_s, ssw_pkg::PER_RST);
  assign wd_act = sup_ok_s && !kick_mid && ctrl_wd_en_q;
  assign st_change = (st_d != st_q);

  always_comb begin
    st_d    = st_q;
    tm_d    = tm_q;
    first_d = first_q;
    fault_d = fault_q;
    if (kick_edge) fault_d = 1'b0;
    unique case (st_q)
      ssw_pkg::RS_HOLD: begin
        tm_d = 13'h0000;
        if (sup_ok_s) st_d = ssw_pkg::RS_PULSE;
      end
      ssw_pkg::RS_PULSE: begin
        if (tick) begin
          if (tm_q == rs_lim - 13'h0001) begin
            st_d    = ssw_pkg::RS_RUN;
            tm_d    = 13'h0000;
            first_d = 1'b1;
          end else begin
            tm_d = tm_q + 13'h0001;
          end
        end
      end
      ssw_pkg::RS_RUN: begin
        if (!wd_act || kick_edge) begin
          tm_d = 13'h0000;
          if (kick_edge) first_d = 1'b0;
        end else if (tick) begin
          if (tm_q == wd_lim - 13'h0001) begin
            // stuck input re-enters here every period: repeated pulses
            st_d    = ssw_pkg::RS_PULSE;
            tm_d    = 13'h0000;
            fault_d = 1'b1;
          end else begin
            tm_d = tm_q + 13'h0001;
          end
        end
      end
      default: st_d = ssw_pkg::RS_HOLD;
    endcase
    if (!wd_act) fault_d = 1'b0;
    if (!sup_ok_s) st_d = ssw_pkg::RS_HOLD;
  end

  // flags; battery state never enters the sequencer above
  logic        rst_n_d;
  logic        batt_d;
  logic        rst_n_q;

  assign rst_n_d = (st_d == ssw_pkg::RS_RUN);
  assign batt_d  = !sup_ok_s && below_batt_s;

  // chip-select gate with write-completion hold
  logic        gate_en;
  logic        hold_q;
  logic        hold_d;
  logic [8:0]  hold_cnt_q;
  logic [8:0]  hold_cnt_d;
  logic        ce_q;
  logic        ce_d;

  assign gate_en = rst_n_d && sup_ok_s;

  always_comb begin
    hold_d     = hold_q;
    hold_cnt_d = hold_cnt_q;
    if (gate_en || mem_sel_in_n_i || batt_d) begin
      hold_d     = 1'b0;
      hold_cnt_d = 9'h000;
    end else if (rst_n_q && !ce_q) begin
      hold_d     = 1'b1;
      hold_cnt_d = 9'h000;
    end else if (hold_q) begin
      if (hold_cnt_q == 9'(`SSW_CE_HOLD_CYC - 1)) hold_d = 1'b0;
      else hold_cnt_d = hold_cnt_q + 9'h001;
    end
  end

  assign ce_d = (gate_en || hold_d) ? mem_sel_in_n_i : 1'b1;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q       <= ssw_pkg::RS_HOLD;
      tm_q       <= 13'h0000;
      first_q    <= 1'b0;
      fault_q    <= 1'b0;
      pre_q      <= 15'h0000;
      osc_prev_q <= 1'b0;
      kick_lvl_q <= 1'b0;
      stab_q     <= 2'h0;
      hold_q     <= 1'b0;
      hold_cnt_q <= 9'h000;
      ce_q       <= 1'b1;
      rst_n_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      tm_q       <= tm_d;
      first_q    <= first_d;
      fault_q    <= fault_d;
      pre_q      <= pre_d;
      osc_prev_q <= osc_s;
      if (kick_edge) kick_lvl_q <= kick_hi_s;
      stab_q     <= stab_d;
      hold_q     <= hold_d;
      hold_cnt_q <= hold_cnt_d;
      ce_q       <= ce_d;
      rst_n_q    <= rst_n_d;
    end
  end

  logic        supply_low_n_q;
  logic        batt_q;
  logic        pf_q;
  logic        bias_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      supply_low_n_q <= 1'b0;
      batt_q    <= 1'b0;
      pf_q      <= 1'b0;
      bias_q    <= 1'b0;
    end else begin
      supply_low_n_q <= sup_ok_s;
      batt_q    <= batt_d;
      pf_q      <= pf_s && !batt_d;
      bias_q    <= sup_ok_s;
    end
  end

  assign rst_n_o         = rst_n_q;
  assign rst_o           = !rst_n_q;
  assign supply_low_n_o  = supply_low_n_q;
  assign on_battery_o    = batt_q;
  assign wd_fault_n_o    = !fault_q;
  assign pf_flag_n_o     = pf_q;
  assign mem_sel_out_n_o = ce_q;
  assign wd_bias_en_o    = bias_q;

  // register slave: control word and live status
  logic        aw_got_q;
  logic [3:0]  awaddr_q;
  logic        w_got_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        wr_do;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_strb0;
  logic        wr_ctrl;
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  assign s_axi_awready_o = !aw_got_q && !bvalid_q;
  assign s_axi_wready_o  = !w_got_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign aw_hs    = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs     = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs    = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_do    = (aw_got_q || aw_hs) && (w_got_q || w_hs) && !bvalid_q;
  assign wr_addr  = aw_got_q ? awaddr_q : s_axi_awaddr_i;
  assign wr_data  = w_got_q ? wdata_q : s_axi_wdata_i;
  assign wr_strb0 = w_got_q ? wstrb0_q : s_axi_wstrb_i[0];
  assign wr_ctrl  = wr_do && wr_strb0 &&
                    ({wr_addr[3:2], 2'b00} == `SSW_OFF_CTRL);

  assign status_w = {22'h000000, st_q, kick_mid, first_q, ce_q, pf_q,
                     !fault_q, batt_q, supply_low_n_q, rst_n_q};
  assign rd_mux =
    ({s_axi_araddr_i[3:2], 2'b00} == `SSW_OFF_CTRL)   ?
      {31'h00000000, ctrl_wd_en_q} :
    ({s_axi_araddr_i[3:2], 2'b00} == `SSW_OFF_STATUS) ? status_w :
      32'h00000000;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_got_q     <= 1'b0;
      awaddr_q     <= 4'h0;
      w_got_q      <= 1'b0;
      wdata_q      <= 32'h00000000;
      wstrb0_q     <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= `SSW_RESP_OKAY;
      ctrl_wd_en_q <= `SSW_CTRL_RST;
    end else begin
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= reg_hit(wr_addr) ? `SSW_RESP_OKAY : `SSW_RESP_SLVERR;
      end else begin
        if (aw_hs) aw_got_q <= 1'b1;
        if (w_hs) w_got_q <= 1'b1;
        if (s_axi_bready_i && bvalid_q) bvalid_q <= 1'b0;
      end
      if (aw_hs) awaddr_q <= s_axi_awaddr_i;
      if (w_hs) begin
        wdata_q  <= s_axi_wdata_i;
        wstrb0_q <= s_axi_wstrb_i[0];
      end
      if (wr_ctrl) ctrl_wd_en_q <= wr_data[`SSW_CTRL_WD_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `SSW_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= reg_hit(s_axi_araddr_i) ? `SSW_RESP_OKAY
                                          : `SSW_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o  = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o  = rdata_q;
  assign s_axi_rresp_o  = rresp_q;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_fault_entry;
    $fell(wd_fault_n_o) ##0 !rst_n_o;
  endsequence

  sequence s_fault_held;
    !wd_fault_n_o && !kick_edge && wd_act;
  endsequence

  a_rst_inverse: assert property (
    rst_o == !rst_n_o
  ) else $error("active-high reset is not the inverse");

  a_supply_low_n_follow: assert property (
    !sup_ok_s |=> !supply_low_n_o
  ) else $error("supply-low flag missed a low supply");

  a_batt_reset: assert property (
    on_battery_o |-> !rst_n_o && !supply_low_n_o
  ) else $error("battery mode without reset asserted");

  a_pf_battery: assert property (
    on_battery_o |-> !pf_flag_n_o && mem_sel_out_n_o
  ) else $error("battery mode outputs wrong");

  a_fault_supply: assert property (
    !supply_low_n_o |-> wd_fault_n_o && !wd_bias_en_o
  ) else $error("watchdog not disabled on low supply");

  a_fault_reset: assert property (
    $fell(wd_fault_n_o) |-> s_fault_entry
  ) else $error("watchdog fault without reset");

  a_fault_hold: assert property (
    s_fault_held ##1 wd_act |-> !wd_fault_n_o
  ) else $error("fault flag released without kick");

  a_mid_disable: assert property (
    kick_mid |=> wd_fault_n_o
  ) else $error("fault flag low with kick input floating");

  a_ce_gate: assert property (
    (!rst_n_o && !hold_q) |-> mem_sel_out_n_o
  ) else $error("chip-select passed during reset");

  a_ce_hold_len: assert property (
    hold_cnt_q <= 9'(`SSW_CE_HOLD_CYC - 1)
  ) else $error("chip-select hold exceeded its time");

  a_first_load: assert property (
    $rose(rst_n_o) |-> first_q && (tm_q == 13'h0000)
  ) else $error("first timeout not loaded at release");

  a_kick_restart: assert property (
    (kick_edge && st_q == ssw_pkg::RS_RUN) |=> tm_q == 13'h0000
  ) else $error("watchdog timer not restarted by kick");

endmodule : ssw_supervisor
`default_nettype wire

//--- tb/ssw_host_model.sv
// host processor model: watchdog kicks and memory chip-select
`default_nettype none
module ssw_host_model (
  input  wire logic clk_i,
  input  wire logic kick_req_i,
  input  wire logic kick_mid_i,
  input  wire logic ce_req_i,
  output logic      wd_kick_hi_o,
  output logic      wd_kick_lo_o,
  output logic      mem_sel_in_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       lvl_q = 1'b0;
  logic [1:0] age_q = 2'h0;
  // requests closer than four cycles are dropped, so a level lasts at least 200 ns
  always_ff @(posedge clk_i) begin
    if (kick_req_i && age_q == 2'h3) begin
      lvl_q <= ~lvl_q;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // an undriven pin reads as neither high nor low
  assign wd_kick_hi_o   = ~kick_mid_i & lvl_q;
  assign wd_kick_lo_o   = ~kick_mid_i & ~lvl_q;
  assign mem_sel_in_n_o = ~ce_req_i;
endmodule : ssw_host_model
`default_nettype wire

//--- tb/supply_supervisor_watchdog_tb_top.sv
// self-checking bench for the supply supervisor
`default_nettype none
`include "ssw_defs.svh"
module supply_supervisor_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS    = 10;
  localparam int PULSE = 200 * MS;
  localparam int FAST  = 100 * MS;
  localparam int FIRST = 1600 * MS;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, supply_ok_i = 1'b0;
  logic        below_batt_i = 1'b0, pf_above_i = 1'b1;
  logic        osc_source_sel_i = 1'b1, osc_ext_in_i = 1'b0;
  logic        kick_req = 1'b0, kick_mid = 1'b1, ce_req = 1'b0;
  logic        ext_run = 1'b0;
  logic        wd_kick_hi_i, wd_kick_lo_i, mem_sel_in_n_i;
  logic        rst_n_o, rst_o, supply_low_n_o, on_battery_o, wd_fault_n_o;
  logic        pf_flag_n_o, mem_sel_out_n_o, wd_bias_en_o;
  logic [3:0]  s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp, ediv = 2'h0;
  int          num_errors = 0, compares = 0, cycles = 0, n;

  ssw_supervisor #(.MS_CYCLES(MS)) DUT (
    .clk_i, .rst_n_i, .supply_ok_i, .below_batt_i, .pf_above_i,
    .wd_kick_hi_i, .wd_kick_lo_i, .osc_source_sel_i, .osc_ext_in_i,
    .mem_sel_in_n_i, .rst_n_o, .rst_o, .supply_low_n_o, .on_battery_o,
    .wd_fault_n_o, .pf_flag_n_o, .mem_sel_out_n_o, .wd_bias_en_o,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i
  );

  ssw_host_model u_host (
    .clk_i,
    .kick_req_i     (kick_req),
    .kick_mid_i     (kick_mid),
    .ce_req_i       (ce_req),
    .wd_kick_hi_o   (wd_kick_hi_i),
    .wd_kick_lo_o   (wd_kick_lo_i),
    .mem_sel_in_n_o (mem_sel_in_n_i)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // external oscillator at a quarter of the system clock
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (ext_run) begin
      ediv <= ediv + 2'h1;
      osc_ext_in_i <= ediv[1];
    end
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi, input int v);
    compares++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : rng

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc

  function automatic logic pick(input int s);
    case (s)
      0:       return rst_n_o;
      1:       return wd_fault_n_o;
      default: return mem_sel_out_n_o;
    endcase
  endfunction : pick

  // the global cycle ceiling bounds this wait
  task automatic wait_for(input int s, input logic v, output int c);
    c = 0;
    while (pick(s) !== v) begin
      @(posedge clk_i);
      c++;
    end
  endtask : wait_for

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!aw || !w) begin
      @(posedge clk_i);
      if (!aw && s_axi_awready_o === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!w && s_axi_wready_o === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    while (s_axi_bvalid_o !== 1'b1) @(posedge clk_i);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar;
    ar = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!ar) begin
      @(posedge clk_i);
      if (s_axi_arready_o === 1'b1) begin
        ar = 1'b1;
        s_axi_arvalid_i <= 1'b0;
      end
    end
    while (s_axi_rvalid_o !== 1'b1) @(posedge clk_i);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : rdr

  task automatic kick;
    kick_req <= 1'b1;
    @(posedge clk_i);
    kick_req <= 1'b0;
  endtask : kick

  initial begin
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(1);
    chk("rst_o", 1, rst_o);
    rdr(`SSW_OFF_STATUS, rd, rsp);
    chk("status", 32'h28, rd & 32'h2f);
    wr(`SSW_OFF_CTRL, 32'h0, rsp);
    chk("ctrl resp", `SSW_RESP_OKAY, rsp);
    rdr(`SSW_OFF_CTRL, rd, rsp);
    chk("ctrl", 32'h0, rd);
    wr(`SSW_OFF_CTRL, 32'h1, rsp);
    rdr(4'h8, rd, rsp);
    chk("unmapped resp", `SSW_RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd);
    // power up on the internal time base, fast watchdog
    ce_req <= 1'b1;
    supply_ok_i <= 1'b1;
    cyc(4);
    chk("supply_low_n", 1, supply_low_n_o);
    chk("mem_sel_out_n", 1, mem_sel_out_n_o);
    wait_for(0, 1'b1, n);
    rng("reset pulse", PULSE, PULSE + 12, n + 4);
    cyc(3);
    chk("mem_sel_out_n", 0, mem_sel_out_n_o);
    chk("rst_o", 0, rst_o);
    kick_mid <= 1'b0;
    repeat (12) begin
      cyc(FAST - 60);
      kick();
    end
    chk("rst_n kicked", 1, rst_n_o);
    wait_for(1, 1'b0, n);
    rng("wd timeout", FAST, FAST + 20, n);
    chk("rst_n at fault", 0, rst_n_o);
    wait_for(0, 1'b1, n);
    rng("wd pulse", PULSE - 2, PULSE + 12, n);
    chk("fault held", 0, wd_fault_n_o);
    wait_for(0, 1'b0, n);
    rng("stuck repeat", FIRST - 2, FIRST + 20, n);
    wait_for(0, 1'b1, n);
    kick();
    cyc(6);
    chk("fault cleared", 1, wd_fault_n_o);
    kick_mid <= 1'b1;
    n = 0;
    repeat (FIRST + 1000) begin
      @(posedge clk_i);
      if (rst_n_o !== 1'b1 || wd_fault_n_o !== 1'b1) n++;
    end
    chk("mid level", 0, n);
    pf_above_i <= 1'b0;
    cyc(4);
    chk("pf_flag_n", 0, pf_flag_n_o);
    chk("rst_n pf", 1, rst_n_o);
    pf_above_i <= 1'b1;
    // supply drops with a write in flight
    supply_ok_i <= 1'b0;
    wait_for(0, 1'b0, n);
    wait_for(2, 1'b1, n);
    rng("ce hold", `SSW_CE_HOLD_CYC - 2, `SSW_CE_HOLD_CYC + 2, n);
    chk("fault low supply", 1, wd_fault_n_o);
    chk("bias", 0, wd_bias_en_o);
    chk("supply_low_n", 0, supply_low_n_o);
    below_batt_i <= 1'b1;
    kick_mid <= 1'b0;
    osc_source_sel_i <= 1'b0;
    cyc(4);
    chk("on_battery", 1, on_battery_o);
    chk("pf battery", 0, pf_flag_n_o);
    chk("mem_sel battery", 1, mem_sel_out_n_o);
    chk("rst_o battery", 1, rst_o);
    below_batt_i <= 1'b0;
    cyc(4);
    chk("on_battery off", 0, on_battery_o);
    // power up again, timed from the external oscillator
    ext_run <= 1'b1;
    supply_ok_i <= 1'b1;
    cyc(4);
    wait_for(0, 1'b1, n);
    n = n + 4;
    rng("ext pulse", 2048 * 4 - 8, 2048 * 4 + 20, n);
    // kick input still stuck: first timeout runs on external edges
    wait_for(1, 1'b0, n);
    rng("ext first", 4096 * 4 - 8, 4096 * 4 + 20, n);
    chk("rst_n ext fault", 0, rst_n_o);
    end_of_test();
  end
endmodule : supply_supervisor_watchdog_tb_top
`default_nettype wire
